// file: bench/brake_relay_model.sv
// behavioural relay that switches the holding-brake coil
`timescale 1ns/100ps
module brake_relay_model (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic coil_drive,
    output logic brake_engaged_ff
);
    // ----------------------------------------------------------------
    // coil follows the drive one cycle late, as a pick-up delay
    // ----------------------------------------------------------------
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            brake_engaged_ff <= 1'b1;
        end else begin
            brake_engaged_ff <= !coil_drive;
        end
    end
endmodule : brake_relay_model

// file: bench/motor_holding_brake_control_test.sv
// self-checking bench for the holding-brake controller
`timescale 1ns/100ps
`include "brake_ctl_consts.svh"
module motor_holding_brake_control_test;
    logic aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready;
    logic arvalid, arready, rvalid, rready, brake_release, engaged;
    logic [`AXI_ADDR_W-1:0] awaddr, araddr;
    logic [`AXI_DATA_W-1:0] wdata, rdata;
    logic [`AXI_STRB_W-1:0] wstrb;
    logic [1:0] bresp, rresp, sw;
    logic [`DIAG_W-1:0] diag_char;
    logic brake_free_req, brake_hold_req, stage_enabled, drive_fault;
    int mismatches;
    int samples_checked;

    brake_ctl uut (.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awvalid(awvalid),
        .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
        .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
        .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
        .brake_free_req(brake_free_req), .brake_hold_req(brake_hold_req),
        .stage_enabled(stage_enabled), .drive_fault(drive_fault),
        .brake_release(brake_release), .diag_char(diag_char));
    brake_relay_model relay (.aclk(aclk), .aresetn(aresetn), .coil_drive(brake_release),
        .brake_engaged_ff(engaged));

    initial begin
        aclk = 1'b0;
        forever #5 aclk = ~aclk;
    end

    task final_report;
        $display("mismatches %0d samples_checked %0d", mismatches, samples_checked);
        if (mismatches == 0 && samples_checked > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : final_report

    task check(input logic [31:0] got, input logic [31:0] exp, input string what);
        samples_checked++;
        if (got !== exp) begin
            mismatches++;
            $display("ERROR %0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask : check

    task timed_out;
        mismatches++;
        $display("ERROR %0t no bus answer", $time);
        final_report();
    endtask : timed_out

    task axi_write(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s,
        input logic [1:0] er);
        int n;
        @(posedge aclk);
        awaddr <= a;
        wdata <= d;
        wstrb <= s;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        for (n = 0; n < 50; n++) begin
            @(posedge aclk);
            if (awvalid && awready) awvalid <= 1'b0;
            if (wvalid && wready) wvalid <= 1'b0;
            if (bvalid) break;
        end
        if (n == 50) timed_out();
        bready <= 1'b0;
        check({30'h0, bresp}, {30'h0, er}, "bresp");
    endtask : axi_write

    task axi_read(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
        int n;
        @(posedge aclk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        for (n = 0; n < 50; n++) begin
            @(posedge aclk);
            if (arvalid && arready) arvalid <= 1'b0;
            if (rvalid) break;
        end
        if (n == 50) timed_out();
        rready <= 1'b0;
        check(rdata, ed, "rdata");
        check({30'h0, rresp}, {30'h0, er}, "rresp");
    endtask : axi_read

    // ----------------------------------------------------------------
    // expected brake state from pins and software bits
    // ----------------------------------------------------------------
    task outputs_ok;
        logic f, h, r;
        repeat (4) @(posedge aclk);
        @(negedge aclk);
        f = brake_free_req | sw[0];
        h = brake_hold_req | sw[1];
        r = f | (!h & stage_enabled & !drive_fault);
        check({31'h0, brake_release}, {31'h0, r}, "brake out");
        check({24'h0, diag_char}, r ? 32'h20 : 32'h62, "display");
        check({31'h0, engaged}, {31'h0, !r}, "relay");
        axi_read(`REG_STAT_OFS, {16'h0, r ? 8'h20 : 8'h62, 3'h0, drive_fault,
            stage_enabled, h, f, r}, `RESP_OKAY);
    endtask : outputs_ok

    task pins(input logic [3:0] p);
        @(posedge aclk);
        {drive_fault, stage_enabled, brake_hold_req, brake_free_req} <= p;
        outputs_ok();
    endtask : pins

    task hold_reset;
        aresetn <= 1'b0;
        @(posedge aclk);
        @(negedge aclk);
        check({31'h0, brake_release}, 32'h0, "reset brake");
        check({24'h0, diag_char}, 32'h62, "reset display");
        @(posedge aclk);
        aresetn <= 1'b1;
        sw = 2'h0;
    endtask : hold_reset

    initial begin
        {aresetn, awvalid, wvalid, bready, arvalid, rready} = 6'h0;
        {awaddr, araddr, wdata, wstrb, sw} = '0;
        {brake_free_req, brake_hold_req, stage_enabled, drive_fault} = 4'h0;
        mismatches = 0;
        samples_checked = 0;
        hold_reset();
        axi_read(`REG_CTRL_OFS, 32'h0, `RESP_OKAY);
        for (int i = 0; i < 16; i++) begin
            pins(i[3:0]);
        end
        // software free beats pin hold and fault
        sw = 2'h1;
        axi_write(`REG_CTRL_OFS, 32'h1, 4'hF, `RESP_OKAY);
        pins(4'hA);
        sw = 2'h2;
        axi_write(`REG_CTRL_OFS, 32'h2, 4'hF, `RESP_OKAY);
        pins(4'h4);
        axi_write(`REG_CTRL_OFS, 32'h1, 4'h0, `RESP_OKAY);
        axi_write(`REG_STAT_OFS, 32'hFFFF, 4'hF, `RESP_OKAY);
        axi_read(`REG_CTRL_OFS, 32'h2, `RESP_OKAY);
        axi_write(8'h0C, 32'h1, 4'hF, `RESP_SLVERR);
        axi_read(8'h08, 32'h0, `RESP_SLVERR);
        sw = 2'h0;
        axi_write(`REG_CTRL_OFS, 32'h0, 4'hF, `RESP_OKAY);
        pins(4'h1);
        hold_reset();
        axi_read(`REG_CTRL_OFS, 32'h0, `RESP_OKAY);
        outputs_ok();
        final_report();
    end
endmodule : motor_holding_brake_control_test

// file: design/brake_ctl.sv
// holding-brake controller with an AXI4-Lite register slave
//
// Overview of operation
// - free request active drives brake output high
// - free request overrides faults and disabled stage
// - hold request alone drives brake output low
// - no request: output follows power-stage enable state, but goes low on a drive fault
// - low output means brake engaged, high released
// - engaged brake shows lower-case b on display
`timescale 1ns/100ps
`include "brake_ctl_consts.svh"
module brake_ctl import brake_ctl_pkg::*; (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [`AXI_ADDR_W-1:0] awaddr,
    input wire logic awvalid,
    output logic awready,
    input wire logic [`AXI_DATA_W-1:0] wdata,
    input wire logic [`AXI_STRB_W-1:0] wstrb,
    input wire logic wvalid,
    output logic wready,
    output logic [1:0] bresp,
    output logic bvalid,
    input wire logic bready,
    input wire logic [`AXI_ADDR_W-1:0] araddr,
    input wire logic arvalid,
    output logic arready,
    output logic [`AXI_DATA_W-1:0] rdata,
    output logic [1:0] rresp,
    output logic rvalid,
    input wire logic rready,
    input wire logic brake_free_req,
    input wire logic brake_hold_req,
    input wire logic stage_enabled,
    input wire logic drive_fault,
    output logic brake_release,
    output logic [`DIAG_W-1:0] diag_char
);

    typedef struct packed {
        wr_state_t wr_st_ff;
        rd_state_t rd_st_ff;
        logic awready_ff;
        logic wready_ff;
        logic aw_got_ff;
        logic w_got_ff;
        logic [`AXI_ADDR_W-1:0] waddr_ff;
        logic [`AXI_DATA_W-1:0] wdata_ff;
        logic [`AXI_STRB_W-1:0] wstrb_ff;
        logic bvalid_ff;
        logic [1:0] bresp_ff;
        logic arready_ff;
        logic rvalid_ff;
        logic [1:0] rresp_ff;
        logic [`AXI_DATA_W-1:0] rdata_ff;
        logic [`CTRL_W-1:0] ctrl_ff;
        logic brake_ff;
        logic [`DIAG_W-1:0] diag_ff;
    } state_t;

    localparam state_t STATE_RST = '{
        wr_st_ff: WR_IDLE,
        rd_st_ff: RD_IDLE,
        awready_ff: 1'b1,
        wready_ff: 1'b1,
        aw_got_ff: 1'b0,
        w_got_ff: 1'b0,
        waddr_ff: '0,
        wdata_ff: '0,
        wstrb_ff: '0,
        bvalid_ff: 1'b0,
        bresp_ff: `RESP_OKAY,
        arready_ff: 1'b1,
        rvalid_ff: 1'b0,
        rresp_ff: `RESP_OKAY,
        rdata_ff: '0,
        ctrl_ff: `CTRL_RST,
        brake_ff: `BRAKE_RST,
        diag_ff: `DIAG_ENGAGED
    };

    state_t s_ff;
    state_t nxt_s;
    logic [`SYNC_W-1:0] pin_s;
    logic free_eff;
    logic hold_eff;
    logic stage_ok;
    logic brake_next;
    logic [`AXI_DATA_W-1:0] stat_word;

    // ----------------------------------------------------------------
    // pin synchronisation
    // ----------------------------------------------------------------
    pin_sync #(
        .W(`SYNC_W)
    ) u_pin_sync (
        .aclk(aclk),
        .aresetn(aresetn),
        .d({drive_fault, stage_enabled, brake_hold_req, brake_free_req}),
        .q(pin_s)
    );

    // ----------------------------------------------------------------
    // brake decision
    // ----------------------------------------------------------------
    // software bits simply join the pins, so either source can free or hold
    assign free_eff = pin_s[`PIN_FREE_BIT] | s_ff.ctrl_ff[`CTRL_FREE_BIT];
    assign hold_eff = pin_s[`PIN_HOLD_BIT] | s_ff.ctrl_ff[`CTRL_HOLD_BIT];
    // a faulted stage counts as disabled for brake purposes
    assign stage_ok = pin_s[`PIN_STAGE_BIT] & ~pin_s[`PIN_FAULT_BIT];

    always_comb begin
        if (free_eff) begin
            brake_next = 1'b1;
        end else if (hold_eff) begin
            brake_next = 1'b0;
        end else begin
            brake_next = stage_ok;
        end
    end

    // ----------------------------------------------------------------
    // status word
    // ----------------------------------------------------------------
    always_comb begin
        stat_word = '0;
        stat_word[`STAT_REL_BIT] = s_ff.brake_ff;
        stat_word[`STAT_FREE_BIT] = free_eff;
        stat_word[`STAT_HOLD_BIT] = hold_eff;
        stat_word[`STAT_STAGE_BIT] = pin_s[`PIN_STAGE_BIT];
        stat_word[`STAT_FAULT_BIT] = pin_s[`PIN_FAULT_BIT];
        stat_word[`STAT_DIAG_MSB:`STAT_DIAG_LSB] = s_ff.diag_ff;
    end

    // ----------------------------------------------------------------
    // next state
    // ----------------------------------------------------------------
    always_comb begin
        nxt_s = s_ff;

        // brake output and display move together, so they never disagree
        nxt_s.brake_ff = brake_next;
        nxt_s.diag_ff = brake_next ? `DIAG_BLANK : `DIAG_ENGAGED;

        // write channel: address and data taken in either order
        case (s_ff.wr_st_ff)
            WR_IDLE: begin
                if (awvalid && s_ff.awready_ff) begin
                    nxt_s.aw_got_ff = 1'b1;
                    nxt_s.waddr_ff = awaddr;
                    nxt_s.awready_ff = 1'b0;
                end
                if (wvalid && s_ff.wready_ff) begin
                    nxt_s.w_got_ff = 1'b1;
                    nxt_s.wdata_ff = wdata;
                    nxt_s.wstrb_ff = wstrb;
                    nxt_s.wready_ff = 1'b0;
                end
                if (nxt_s.aw_got_ff && nxt_s.w_got_ff) begin
                    nxt_s.aw_got_ff = 1'b0;
                    nxt_s.w_got_ff = 1'b0;
                    nxt_s.bvalid_ff = 1'b1;
                    nxt_s.wr_st_ff = WR_RESP;
                    if (nxt_s.waddr_ff == `REG_CTRL_OFS) begin
                        nxt_s.bresp_ff = `RESP_OKAY;
                        if (nxt_s.wstrb_ff[`WSTRB_CTRL_BYTE]) begin
                            nxt_s.ctrl_ff = nxt_s.wdata_ff[`CTRL_W-1:0];
                        end
                    end else if (nxt_s.waddr_ff == `REG_STAT_OFS) begin
                        // status is read-only; the write is dropped quietly
                        nxt_s.bresp_ff = `RESP_OKAY;
                    end else begin
                        nxt_s.bresp_ff = `RESP_SLVERR;
                    end
                end
            end
            WR_RESP: begin
                if (bready) begin
                    nxt_s.bvalid_ff = 1'b0;
                    nxt_s.awready_ff = 1'b1;
                    nxt_s.wready_ff = 1'b1;
                    nxt_s.wr_st_ff = WR_IDLE;
                end
            end
            default: begin
                nxt_s.wr_st_ff = WR_IDLE;
            end
        endcase

        // read channel
        case (s_ff.rd_st_ff)
            RD_IDLE: begin
                if (arvalid && s_ff.arready_ff) begin
                    nxt_s.arready_ff = 1'b0;
                    nxt_s.rvalid_ff = 1'b1;
                    nxt_s.rd_st_ff = RD_DATA;
                    if (araddr == `REG_CTRL_OFS) begin
                        nxt_s.rdata_ff = '0;
                        nxt_s.rdata_ff[`CTRL_W-1:0] = s_ff.ctrl_ff;
                        nxt_s.rresp_ff = `RESP_OKAY;
                    end else if (araddr == `REG_STAT_OFS) begin
                        nxt_s.rdata_ff = stat_word;
                        nxt_s.rresp_ff = `RESP_OKAY;
                    end else begin
                        nxt_s.rdata_ff = '0;
                        nxt_s.rresp_ff = `RESP_SLVERR;
                    end
                end
            end
            RD_DATA: begin
                if (rready) begin
                    nxt_s.rvalid_ff = 1'b0;
                    nxt_s.arready_ff = 1'b1;
                    nxt_s.rd_st_ff = RD_IDLE;
                end
            end
            default: begin
                nxt_s.rd_st_ff = RD_IDLE;
            end
        endcase
    end

    // ----------------------------------------------------------------
    // state register
    // ----------------------------------------------------------------
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_ff <= STATE_RST;
        end else begin
            s_ff <= nxt_s;
        end
    end

    // ----------------------------------------------------------------
    // outputs
    // ----------------------------------------------------------------
    assign awready = s_ff.awready_ff;
    assign wready = s_ff.wready_ff;
    assign bvalid = s_ff.bvalid_ff;
    assign bresp = s_ff.bresp_ff;
    assign arready = s_ff.arready_ff;
    assign rvalid = s_ff.rvalid_ff;
    assign rresp = s_ff.rresp_ff;
    assign rdata = s_ff.rdata_ff;
    // motion logic elsewhere should check this before commanding moves
    assign brake_release = s_ff.brake_ff;
    assign diag_char = s_ff.diag_ff;

    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    chk_free_release: assert property (
        @(posedge aclk) disable iff (!aresetn)
        free_eff |=> brake_release)
        else $error("free request did not release the brake");

    chk_free_over_fault: assert property (
        @(posedge aclk) disable iff (!aresetn)
        (free_eff && (pin_s[`PIN_FAULT_BIT] || !pin_s[`PIN_STAGE_BIT]))
        ##1 free_eff |-> brake_release [*2])
        else $error("free request lost against fault or disabled stage");

    chk_hold_engage: assert property (
        @(posedge aclk) disable iff (!aresetn)
        (!free_eff && hold_eff) |=> !brake_release)
        else $error("hold request did not engage the brake");

    chk_stage_follow: assert property (
        @(posedge aclk) disable iff (!aresetn)
        (!free_eff && !hold_eff) |=> (brake_release == $past(stage_ok)))
        else $error("brake does not follow the stage state");

    chk_engage_cause: assert property (
        @(posedge aclk) disable iff (!aresetn)
        $fell(brake_release) |-> $past(!free_eff && (hold_eff || !stage_ok)))
        else $error("brake engaged without a cause");

    chk_diag_char: assert property (
        @(posedge aclk) disable iff (!aresetn)
        (brake_release ? diag_char == `DIAG_BLANK : diag_char == `DIAG_ENGAGED))
        else $error("display disagrees with brake state");

    chk_reset_engaged: assert property (
        @(posedge aclk)
        !aresetn |=> (!brake_release && diag_char == `DIAG_ENGAGED))
        else $error("brake not engaged during reset");

    chk_pin_latency: assert property (
        @(posedge aclk) disable iff (!aresetn)
        (!brake_free_req && brake_hold_req && s_ff.ctrl_ff == `CTRL_RST) [*3]
        |=> !brake_release)
        else $error("held hold pin did not engage within three cycles");

    cov_free_fault: cover property (
        @(posedge aclk) disable iff (!aresetn)
        free_eff && pin_s[`PIN_FAULT_BIT] ##1 brake_release);

    cov_hold_engage: cover property (
        @(posedge aclk) disable iff (!aresetn)
        brake_release ##1 !brake_release && hold_eff);

    cov_ctrl_write: cover property (
        @(posedge aclk) disable iff (!aresetn)
        bvalid && bready && bresp == `RESP_OKAY);

endmodule : brake_ctl

// file: design/brake_ctl_consts.svh
// constants for the holding-brake controller: offsets, fields, codes, reset values
`ifndef BRAKE_CTL_CONSTS_SVH
`define BRAKE_CTL_CONSTS_SVH

// ----------------------------------------------------------------
// bus geometry and answers
// ----------------------------------------------------------------
`define AXI_ADDR_W 8
`define AXI_DATA_W 32
`define AXI_STRB_W 4
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2

// ----------------------------------------------------------------
// register map
// ----------------------------------------------------------------
`define REG_CTRL_OFS 8'h00
`define REG_STAT_OFS 8'h04
`define CTRL_W 2
`define CTRL_RST 2'h0
`define CTRL_FREE_BIT 0
`define CTRL_HOLD_BIT 1
`define WSTRB_CTRL_BYTE 0
`define STAT_REL_BIT 0
`define STAT_FREE_BIT 1
`define STAT_HOLD_BIT 2
`define STAT_STAGE_BIT 3
`define STAT_FAULT_BIT 4
`define STAT_DIAG_LSB 8
`define STAT_DIAG_MSB 15

// ----------------------------------------------------------------
// pins, display and reset values
// ----------------------------------------------------------------
`define SYNC_W 4
`define PIN_FREE_BIT 0
`define PIN_HOLD_BIT 1
`define PIN_STAGE_BIT 2
`define PIN_FAULT_BIT 3
`define DIAG_W 8
`define DIAG_ENGAGED 8'h62
`define DIAG_BLANK 8'h20
`define BRAKE_RST 1'b0

`endif

// file: design/brake_ctl_pkg.sv
// types shared by the holding-brake controller
package brake_ctl_pkg;

    // ----------------------------------------------------------------
    // bus channel states
    // ----------------------------------------------------------------
    typedef enum logic [0:0] {
        WR_IDLE = 1'b0,
        WR_RESP = 1'b1
    } wr_state_t;

    typedef enum logic [0:0] {
        RD_IDLE = 1'b0,
        RD_DATA = 1'b1
    } rd_state_t;

endpackage : brake_ctl_pkg

// file: design/pin_sync.sv
// two-flop synchroniser for a group of asynchronous pin levels
`timescale 1ns/100ps
module pin_sync #(
    parameter int W = 1
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [W-1:0] d,
    output logic [W-1:0] q
);

    typedef struct packed {
        logic [W-1:0] meta_ff;
        logic [W-1:0] sync_ff;
    } sync_state_t;

    sync_state_t s_ff;
    sync_state_t nxt_s;

    // ----------------------------------------------------------------
    // meta stage feeds only the sync stage
    // ----------------------------------------------------------------
    always_comb begin
        nxt_s = s_ff;
        nxt_s.meta_ff = d;
        nxt_s.sync_ff = s_ff.meta_ff;
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_ff <= '0;
        end else begin
            s_ff <= nxt_s;
        end
    end

    assign q = s_ff.sync_ff;

endmodule : pin_sync
